// ==== spra_regs.sv ====
// Result registers, current and power math and alert selection
`timescale 1ns/100ps
`default_nettype none
module spra_regs (
  input wire logic sys_clk, // Device clock, 10 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic link_clk, // Host bit clock
  input wire logic frame_n, // Host frame select, active low
  input wire logic sda_in, // Serial data in
  output logic sda_out, // Serial data out
  output logic sda_oe, // Serial data drive enable
  input wire logic sample_valid, // One-cycle pulse per converter sample
  input wire logic [15:0] shunt_drop, // Signed shunt sample
  input wire logic [14:0] supply_rail_voltage, // Bus sample
  input wire logic [2:0] avg_sel, // Averaging code
  input wire logic cfg_write_clear, // Pulse, config written, not power-down
  input wire logic [15:0] alert_limit_bits, // Alert limit value
  output logic alert_out, // Alert pin data, always low
  output logic alert_oe // Alert pin pull-down enable
);
  logic [15:0] shunt_voltage_result;
  logic [15:0] bus_voltage_result;
  logic [15:0] power_result;
  logic [15:0] current_result;
  logic [15:0] calibration_value;
  logic [4:0] alert_fn_en;
  logic done_alert_en;
  logic limit_alert_flag;
  logic conversion_done_flag;
  logic math_overflow_flag;
  logic alert_polarity_sel;
  logic alert_latch_sel;
  logic [15:0] rd_word;
  logic [2:0] wr_sync;
  logic [2:0] rd_sync;
  logic [25:0] acc_shunt;
  logic [24:0] acc_bus;
  logic [10:0] avg_cnt;
  logic st_avg;
  logic st_cur;
  logic st_pow;
  logic cur_overflow_q;
  logic link_wr;
  logic link_rd;
  logic [7:0] link_addr;
  logic [15:0] link_data;

  // ==========================================
  // Serial port on the link clock
  spra_link u_link (
    .link_clk(link_clk),
    .frame_n(frame_n),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_req(link_wr),
    .rd_req(link_rd),
    .req_addr(link_addr),
    .wr_data(link_data),
    .rd_word(rd_word)
  );

  // Requests are levels; address and data are stable while they stand
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_sync <= 3'h0;
      rd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], link_wr};
      rd_sync <= {rd_sync[1:0], link_rd};
    end
  end

  wire logic wr_evt = wr_sync[1] && !wr_sync[2];
  wire logic rd_evt = rd_sync[1] && !rd_sync[2];
  wire logic cal_wr = wr_evt && link_addr == spra_pkg::ADDR_CAL;
  wire logic mask_wr = wr_evt && link_addr == spra_pkg::ADDR_MASK;
  wire logic mask_rd = rd_evt && link_addr == spra_pkg::ADDR_MASK;

  // ==========================================
  // Read view
  wire logic [15:0] mask_view = {alert_fn_en, done_alert_en, 5'h00,
    limit_alert_flag, conversion_done_flag, math_overflow_flag,
    alert_polarity_sel, alert_latch_sel};
  wire logic [15:0] read_mux =
    (link_addr == spra_pkg::ADDR_SHUNT) ? shunt_voltage_result :
    (link_addr == spra_pkg::ADDR_BUS) ? bus_voltage_result :
    (link_addr == spra_pkg::ADDR_POWER) ? power_result :
    (link_addr == spra_pkg::ADDR_CURRENT) ? current_result :
    (link_addr == spra_pkg::ADDR_CAL) ? calibration_value :
    (link_addr == spra_pkg::ADDR_MASK) ? mask_view : 16'h0000;

  // Captured once per read; the gap bits cover the crossing delay
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_word <= spra_pkg::RESET_WORD;
    end else if (rd_evt) begin
      rd_word <= read_mux;
    end
  end

  // ==========================================
  // Control registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      calibration_value <= spra_pkg::RESET_WORD;
      alert_fn_en <= 5'h00;
      done_alert_en <= 1'b0;
      alert_polarity_sel <= 1'b0;
      alert_latch_sel <= 1'b0;
    end else begin
      if (cal_wr) begin
        // Top bit is dropped so it always reads zero
        calibration_value <= link_data & spra_pkg::CAL_WRITE_BITS;
      end
      if (mask_wr) begin
        alert_fn_en <= link_data[15:spra_pkg::MASK_FN_LSB];
        done_alert_en <= link_data[spra_pkg::MASK_DONE_EN];
        alert_polarity_sel <= link_data[spra_pkg::MASK_POLARITY];
        alert_latch_sel <= link_data[spra_pkg::MASK_LATCH];
      end
    end
  end

  // ==========================================
  // Averaging
  wire logic [3:0] avg_sh = spra_pkg::avg_shift(avg_sel);
  wire logic [10:0] avg_target = 11'(11'h001 << avg_sh);
  wire logic last_sample = sample_valid && (avg_cnt + 11'h001 == avg_target);
  wire logic signed [25:0] shunt_sum =
    $signed(acc_shunt) + $signed({{10{shunt_drop[15]}}, shunt_drop});
  wire logic [24:0] bus_sum = acc_bus + {10'h000, supply_rail_voltage};
  wire logic signed [25:0] shunt_avg = shunt_sum >>> avg_sh;
  wire logic [24:0] bus_avg = bus_sum >> avg_sh;

  // Averaging code changes take effect at once, in the block already in progress
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      acc_shunt <= 26'h0000000;
      acc_bus <= 25'h0000000;
      avg_cnt <= 11'h000;
    end else if (last_sample) begin
      acc_shunt <= 26'h0000000;
      acc_bus <= 25'h0000000;
      avg_cnt <= 11'h000;
    end else if (sample_valid) begin
      acc_shunt <= shunt_sum;
      acc_bus <= bus_sum;
      avg_cnt <= avg_cnt + 11'h001;
    end
  end

  // ==========================================
  // Current and power, one stage each
  wire logic signed [31:0] cur_prod = $signed(shunt_voltage_result) *
    $signed({1'b0, calibration_value[14:0]});
  wire logic signed [31:0] cur_full = cur_prod >>> spra_pkg::CURRENT_SHIFT;
  wire logic cur_overflow = cur_full[31:15] != {17{cur_full[15]}};
  wire logic [15:0] cur_mag = current_result[spra_pkg::SIGN_BIT] ?
    16'(-current_result) : current_result;
  wire logic [30:0] pow_prod = cur_mag * bus_voltage_result[14:0];
  wire logic [30:0] pow_full = pow_prod / 31'(spra_pkg::POWER_DIV);
  wire logic pow_overflow = |pow_full[30:16];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shunt_voltage_result <= spra_pkg::RESET_WORD;
      bus_voltage_result <= spra_pkg::RESET_WORD;
      current_result <= spra_pkg::RESET_WORD;
      power_result <= spra_pkg::RESET_WORD;
      cur_overflow_q <= 1'b0;
      st_avg <= 1'b0;
      st_cur <= 1'b0;
      st_pow <= 1'b0;
    end else begin
      st_avg <= last_sample;
      st_cur <= st_avg;
      st_pow <= st_cur;
      if (last_sample) begin
        shunt_voltage_result <= shunt_avg[15:0];
        bus_voltage_result <= {1'b0, bus_avg[14:0]};
      end
      if (st_avg) begin
        current_result <= cur_full[15:0];
        cur_overflow_q <= cur_overflow;
      end
      if (st_cur) begin
        power_result <= pow_full[15:0];
      end
    end
  end

  // ==========================================
  // Limit check and flags
  wire logic conv_done = st_pow;
  wire logic shunt_high_hit =
    $signed(shunt_voltage_result) > $signed(alert_limit_bits);
  wire logic shunt_low_hit =
    $signed(shunt_voltage_result) < $signed(alert_limit_bits);
  wire logic bus_high_hit = bus_voltage_result > alert_limit_bits;
  wire logic bus_low_hit = bus_voltage_result < alert_limit_bits;
  wire logic power_high_hit = power_result > alert_limit_bits;
  wire logic limit_hit = alert_fn_en[4] ? shunt_high_hit :
    alert_fn_en[3] ? shunt_low_hit :
    alert_fn_en[2] ? bus_high_hit :
    alert_fn_en[1] ? bus_low_hit :
    alert_fn_en[0] && power_high_hit;
  wire logic latch_clear = mask_rd && alert_latch_sel;
  wire logic held_flag = limit_alert_flag && !latch_clear;
  // A new hit in the clearing cycle wins over the clear
  wire logic next_limit_flag = !conv_done ? held_flag :
    alert_latch_sel ? (held_flag || limit_hit) : limit_hit;
  wire logic next_done_flag = conv_done ||
    (conversion_done_flag && !mask_rd && !cfg_write_clear);
  wire logic alert_active = (limit_alert_flag && |alert_fn_en) ||
    (done_alert_en && conversion_done_flag);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      limit_alert_flag <= 1'b0;
      conversion_done_flag <= 1'b0;
      math_overflow_flag <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      limit_alert_flag <= next_limit_flag;
      conversion_done_flag <= next_done_flag;
      if (conv_done) begin
        math_overflow_flag <= cur_overflow_q || pow_overflow;
      end
      // Open drain: pull low when the idle or active level is low
      alert_oe <= alert_active ^ alert_polarity_sel;
    end
  end

  assign alert_out = 1'b0;

  // ==========================================
  // Checks
  default clocking ast_clk @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence seq_math;
    st_cur ##1 st_pow;
  endsequence

  AST_MATH_ORDER: assert property (
    st_avg |=> seq_math ##1 conversion_done_flag)
    else $error("done flag not after current and power stages");
  AST_AVG_ONE: assert property (
    sample_valid && avg_sel == 3'h0 |=> st_avg)
    else $error("single sample did not finish a block");
  AST_BUS_TOP_ZERO: assert property (
    !bus_voltage_result[spra_pkg::SIGN_BIT])
    else $error("bus reading top bit set");
  AST_RESERVED_ZERO: assert property (
    !calibration_value[15] && mask_view[9:5] == 5'h00)
    else $error("unused bit reads nonzero");
  AST_DONE_CLEAR: assert property (
    mask_rd && !conv_done |=> !conversion_done_flag)
    else $error("done flag survived mask read");
  AST_LATCH_HOLD: assert property (
    limit_alert_flag && alert_latch_sel && !mask_rd |=> limit_alert_flag)
    else $error("latched alert dropped without mask read");
  AST_TRANSPARENT: assert property (
    conv_done && !alert_latch_sel && !limit_hit |=> !limit_alert_flag)
    else $error("transparent alert held after clean conversion");
  AST_PRIORITY: assert property (
    conv_done && alert_fn_en[4] && shunt_high_hit |=> limit_alert_flag)
    else $error("highest alert function ignored");
  AST_POLARITY: assert property (
    alert_active && !alert_polarity_sel |=> alert_oe)
    else $error("active-low alert not pulled low");
  AST_OVERFLOW: assert property (
    st_avg && cur_overflow |=> ##2 math_overflow_flag)
    else $error("current overflow not flagged");
  AST_CAL_USED: assert property (
    cal_wr |=> calibration_value ==
      ($past(link_data) & spra_pkg::CAL_WRITE_BITS))
    else $error("calibration write lost");
endmodule : spra_regs
`default_nettype wire

// ==== spra_pkg.sv ====
// Shared constants for the shunt, bus, current and power result registers
package spra_pkg;
  // ==========================================
  // Register pointers
  localparam logic [7:0] ADDR_SHUNT = 8'h01;
  localparam logic [7:0] ADDR_BUS = 8'h02;
  localparam logic [7:0] ADDR_POWER = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_CAL = 8'h05;
  localparam logic [7:0] ADDR_MASK = 8'h06;
  // ==========================================
  // Field positions and reset values
  localparam int SIGN_BIT = 15;
  localparam int BUS_FIELD_MSB = 14;
  localparam int MASK_FN_LSB = 11;
  localparam int MASK_DONE_EN = 10;
  localparam int MASK_LIMIT_FLAG = 4;
  localparam int MASK_DONE_FLAG = 3;
  localparam int MASK_OVERFLOW = 2;
  localparam int MASK_POLARITY = 1;
  localparam int MASK_LATCH = 0;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] CAL_WRITE_BITS = 16'h7fff;
  // ==========================================
  // Scaling
  localparam int SHUNT_LSB_NV = 2500;
  localparam int SHUNT_FULL_SCALE_UV = 81920;
  localparam int BUS_LSB_UV = 1250;
  localparam int CURRENT_SHIFT = 11;
  localparam int POWER_LSB_RATIO = 25;
  // Power count = current count * bus count * bus LSB / power LSB
  localparam int POWER_DIV = POWER_LSB_RATIO * 1000000 / BUS_LSB_UV;
  // ==========================================
  // Serial frame layout, in link clock bits
  localparam int LINK_CMD_BITS = 8;
  localparam int LINK_GAP_BITS = 8;
  localparam int LINK_DATA_BITS = 16;
  localparam int LINK_READ_BIT = 7;

  // Averaging code to log2 of sample count
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction : avg_shift
endpackage : spra_pkg

// ==== spra_link.sv ====
// Serial register port logic running on the host's link clock
`timescale 1ns/100ps
`default_nettype none
module spra_link (
  input wire logic link_clk, // Bit clock from the host
  input wire logic frame_n, // Low for the length of one frame
  input wire logic sda_in, // Serial data from the host
  output logic sda_out, // Serial data to the host
  output logic sda_oe, // High while this end drives data
  output logic wr_req, // High from write completion to frame end
  output logic rd_req, // High from command end to frame end
  output logic [7:0] req_addr, // Register pointer of the frame
  output logic [15:0] wr_data, // Write word, stable while wr_req is high
  input wire logic [15:0] rd_word // Read word, loaded during the gap bits, stable at the last one
);
  localparam int CMD_END = spra_pkg::LINK_CMD_BITS - 1;
  localparam int GAP_END = CMD_END + spra_pkg::LINK_GAP_BITS;
  localparam int WR_END = CMD_END + spra_pkg::LINK_DATA_BITS;
  localparam int CNT_MAX = GAP_END + spra_pkg::LINK_DATA_BITS + 1;

  logic [5:0] bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic is_read;

  wire logic [15:0] next_shift_in = {shift_in[14:0], sda_in};
  wire logic cmd_end = bit_cnt == 6'(CMD_END);
  wire logic gap_end = bit_cnt == 6'(GAP_END);
  wire logic wr_end = bit_cnt == 6'(WR_END);
  wire logic next_read = next_shift_in[spra_pkg::LINK_READ_BIT];

  // ==========================================
  // Frame control; a stopped clock leaves this to frame_n
  always_ff @(posedge link_clk or posedge frame_n) begin
    if (frame_n) begin
      bit_cnt <= 6'h00;
      is_read <= 1'b0;
      wr_req <= 1'b0;
      rd_req <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      if (bit_cnt != 6'(CNT_MAX)) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (cmd_end) begin
        is_read <= next_read;
        rd_req <= next_read;
      end
      if (wr_end && !is_read) begin
        wr_req <= 1'b1;
      end
      if (gap_end && is_read) begin
        sda_oe <= 1'b1;
        sda_out <= rd_word[15];
      end else if (sda_oe) begin
        sda_out <= shift_out[15];
      end
    end
  end

  // ==========================================
  // Data path; no reset, qualified by the control above
  always_ff @(posedge link_clk) begin
    shift_in <= next_shift_in;
    if (cmd_end) begin
      req_addr <= {1'b0, next_shift_in[6:0]};
    end
    if (wr_end && !is_read) begin
      wr_data <= next_shift_in;
    end
    if (gap_end && is_read) begin
      shift_out <= {rd_word[14:0], 1'b0};
    end else begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  AST_LINK_NO_DRIVE_ON_WRITE: assert property (
    @(posedge link_clk) disable iff (frame_n)
    !is_read |-> !sda_oe)
    else $error("data driven during a write frame");
endmodule : spra_link
`default_nettype wire

// ==== spra_host_model.sv ====
// Host model driving the serial register port
`timescale 1ns/100ps
`default_nettype none
module spra_host_model (
  output logic link_clk, // Bit clock, still between frames
  output logic frame_n, // Frame select, active low
  output logic sda_in, // Serial data to the device
  input wire logic sda_out, // Serial data from the device
  input wire logic sda_oe, // Device drive enable
  output logic rd_valid, // Pulse when a read word is complete
  output logic [15:0] rd_data // Last word read
);
  initial begin
    link_clk = 1'b0;
    frame_n = 1'b1;
    sda_in = 1'b1;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end

  // ==========================================
  // Frame engine
  // Unused bits toggle every clock so a stale level never looks valid
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd);
    logic [31:0] bits;
    int n;
    n = cmd[7] ? 32 : 24;
    bits = cmd[7] ? {cmd, 24'h555555} : {cmd, wd, 8'h00};
    frame_n = 1'b0;
    #230;
    for (int i = 0; i < n; i++) begin
      sda_in = bits[31 - i];
      #80;
      // Taken just ahead of the edge, while the last shifted bit stands
      if (i >= 16) rd_data = {rd_data[14:0], sda_oe ? sda_out : ~sda_out};
      link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    // Frame held low past the device's write hand-off
    #400 frame_n = 1'b1;
    sda_in = ~sda_in;
    if (cmd[7]) begin
      rd_valid = 1'b1;
      #1 rd_valid = 1'b0;
    end
    #420;
  endtask : frame

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    frame({1'b0, a[6:0]}, d);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a);
    frame({1'b1, a[6:0]}, 16'h0000);
  endtask : read_reg
endmodule : spra_host_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the result and alert registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk, srst, link_clk, frame_n, sda_in, sda_out, sda_oe;
  logic sample_valid, cfg_write_clear, alert_out, alert_oe, rd_valid;
  logic [15:0] shunt_drop, alert_limit_bits, rd_data;
  logic [14:0] supply_rail_voltage;
  logic [2:0] avg_sel;
  logic [23:0] exp_q[$];
  int n_fail = 0;
  int check_count = 0;

  spra_regs spra_regs_i (.sys_clk, .srst, .link_clk, .frame_n, .sda_in,
    .sda_out, .sda_oe, .sample_valid, .shunt_drop, .supply_rail_voltage,
    .avg_sel, .cfg_write_clear, .alert_limit_bits, .alert_out, .alert_oe);
  spra_host_model spra_host_model_i (.link_clk, .frame_n, .sda_in,
    .sda_out, .sda_oe, .rd_valid, .rd_data);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================
  // Checking and closing
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge rd_valid) begin
    if (exp_q.size() > 0) begin
      logic [23:0] e;
      e = exp_q.pop_front();
      check($sformatf("reg %h", e[23:16]), rd_data, e[15:0]);
    end else begin
      n_fail++;
      $display("[FAIL] read word expected none seen %h", rd_data);
    end
  end

  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end

  // ==========================================
  // Stimulus tasks
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back({a, e});
    spra_host_model_i.read_reg(a);
    @(negedge sys_clk);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    spra_host_model_i.write_reg(a, d);
    @(negedge sys_clk);
  endtask : wr

  task automatic smp(input logic [15:0] s, input logic [14:0] b);
    @(negedge sys_clk);
    shunt_drop = s;
    supply_rail_voltage = b;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask : smp

  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] s, c, cur, pw;
    logic [14:0] b;
    int ci, r;
    logic [15:0] sv[5];
    logic [14:0] bv[5];
    sv = '{16'h0200, 16'h0080, 16'h0080, 16'h0080, 16'h0200};
    bv = '{15'h0080, 15'h0200, 15'h0200, 15'h0080, 15'h7d00};
    srst = 1'b1;
    sample_valid = 1'b0;
    cfg_write_clear = 1'b0;
    shunt_drop = 16'h0000;
    supply_rail_voltage = 15'h0000;
    avg_sel = 3'h0;
    alert_limit_bits = 16'h0000;
    void'($urandom(29674));
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int a = 0; a < 8; a++) rd(8'(a), 16'h0000);
    wr(8'h05, 16'hffff);
    rd(8'h05, 16'h7fff);
    wr(8'h01, 16'h1234);
    rd(8'h01, 16'h0000);
    $display("reset and access done");
    for (int k = 0; k < 2; k++) begin
      c = 16'($urandom_range(4095, 1));
      r = int'($urandom_range(4000, 1));
      s = k ? 16'(r) : 16'(-r);
      b = 15'($urandom_range(32767, 0));
      wr(8'h05, c);
      smp(s, b);
      cur = 16'((longint'($signed(s)) * longint'(c))
                >>> spra_pkg::CURRENT_SHIFT);
      ci = $signed(cur);
      pw = 16'((ci < 0 ? -ci : ci) * b / spra_pkg::POWER_DIV);
      rd(8'h01, s);
      rd(8'h02, {1'b0, b});
      rd(8'h04, cur);
      rd(8'h03, pw);
      rd(8'h06, 16'h0008);
      rd(8'h06, 16'h0000);
    end
    $display("conversion math done");
    avg_sel = 3'h1;
    for (int k = 0; k < 4; k++) begin
      smp(s + 16'h0040 + 16'(4 * k), b);
      if (k == 2) rd(8'h01, s);
      if (k == 2) rd(8'h06, 16'h0000);
    end
    rd(8'h01, s + 16'h0046);
    cfg_write_clear = 1'b1;
    @(negedge sys_clk);
    cfg_write_clear = 1'b0;
    avg_sel = 3'h0;
    rd(8'h06, 16'h0000);
    wr(8'h05, 16'h7fff);
    smp(16'h7fff, 15'h7fff);
    rd(8'h06, 16'h000c);
    $display("averaging and flags done");
    wr(8'h05, 16'h0800);
    alert_limit_bits = 16'h0100;
    for (int f = 0; f < 5; f++) begin
      wr(8'h06, 16'h03fd | (16'h8000 >> f));
      smp(sv[f], bv[f]);
      check("alert pin", {15'h0, alert_oe}, 16'h0001);
      rd(8'h06, 16'h0019 | (16'h8000 >> f));
    end
    wr(8'h06, 16'ha001);
    smp(16'hff00, 15'h0200);
    check("priority pin", {15'h0, alert_oe}, 16'h0000);
    rd(8'h06, 16'ha009);
    wr(8'h06, 16'h2001);
    smp(16'h0000, 15'h0200);
    smp(16'h0000, 15'h0080);
    check("latched pin", {15'h0, alert_oe}, 16'h0001);
    rd(8'h06, 16'h2019);
    check("released pin", {15'h0, alert_oe}, 16'h0000);
    wr(8'h06, 16'h2002);
    smp(16'h0000, 15'h0080);
    check("high idle pin", {15'h0, alert_oe}, 16'h0001);
    smp(16'h0000, 15'h0200);
    check("high active pin", {15'h0, alert_oe}, 16'h0000);
    smp(16'h0000, 15'h0080);
    check("transparent pin", {15'h0, alert_oe}, 16'h0001);
    // Conversion-ready as the only alert source, active low
    wr(8'h06, 16'h0400);
    smp(16'h0000, 15'h0080);
    check("done pin", {15'h0, alert_oe}, 16'h0001);
    check("alert data", {15'h0, alert_out}, 16'h0000);
    rd(8'h06, 16'h0408);
    check("done cleared pin", {15'h0, alert_oe}, 16'h0000);
    $display("alert selection done");
    // Reset in mid-run with the link idle
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("reset pin", {15'h0, alert_oe}, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h05, 16'h0000);
    $display("second reset done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
